// file: rtl/pin_mux_pkg.sv
// Constants, types and register map for the sync pin and video bus multiplexer
`default_nettype none
package pin_mux_pkg;
  localparam int NUM_CH = 4;
  localparam int BYTE_W = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_PIN12_CTRL   = 8'hC8;
  localparam logic [7:0] ADDR_PIN34_CTRL   = 8'hC9;
  localparam logic [7:0] ADDR_BUS_MODE     = 8'hCA;
  localparam logic [7:0] ADDR_PIN_INVERT   = 8'hCB;
  localparam logic [7:0] ADDR_SECOND_SEL   = 8'hCC;
  localparam logic [7:0] ADDR_FIRST_SEL    = 8'hCD;

  // Field layout
  localparam int PIN_STRIDE  = 4;
  localparam int FN_W        = 3;
  localparam int GP_OFS      = 3;
  localparam int INVERT_POS  = 4;
  localparam int SEL_W       = 2;

  // Reset values
  localparam logic [7:0] RST_PIN_CTRL   = 8'h00;
  localparam logic [7:0] RST_BUS_MODE   = 8'h00;
  localparam logic [7:0] RST_PIN_INVERT = 8'h00;
  localparam logic [7:0] RST_SECOND_SEL = 8'h39;
  localparam logic [7:0] RST_FIRST_SEL  = 8'hE4;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [1:0] SLOT_STEP      = 2'h1;

  typedef enum logic [2:0] {
    FN_HSYNC     = 3'h0,
    FN_VSYNC     = 3'h1,
    FN_FIELD     = 3'h2,
    FN_HACTIVE   = 3'h3,
    FN_VH_ACTIVE = 3'h4,
    FN_NO_VIDEO  = 3'h5,
    FN_CSYNC     = 3'h6,
    FN_GP_LEVEL  = 3'h7
  } pin_function_t;

  typedef enum logic [1:0] {
    MUX_SINGLE   = 2'h0,
    MUX_TWO      = 2'h1,
    MUX_FOUR     = 2'h2,
    MUX_RESERVED = 2'h3
  } bus_mux_mode_t;

  // Per-channel timing from the decoder core
  typedef struct packed {
    logic hsync_n;
    logic vsync_n;
    logic field_even;
    logic h_active;
    logic v_active;
    logic no_video;
    logic video_loss;
  } chan_timing_t;
endpackage : pin_mux_pkg
`default_nettype wire

// file: rtl/sync_pin_and_video_bus_mux.sv
// Multi-purpose sync pins and time-multiplexed video output buses
`default_nettype none

module sync_pin_and_video_bus_mux
  import pin_mux_pkg::*;
(
  // Clock and reset
  input  wire  logic                                         i_clk,
  input  wire  logic                                         i_arst_n,
  // Register port
  input  wire  logic [7:0]                                   i_reg_addr,
  input  wire  logic                                         i_reg_wr,
  input  wire  logic                                         i_reg_rd,
  input  wire  logic [7:0]                                   i_reg_wdata,
  output logic [7:0]                                         o_reg_rdata,
  // Decoder channel sources
  input  wire  pin_mux_pkg::chan_timing_t [pin_mux_pkg::NUM_CH-1:0] i_chan_timing,
  input  wire  logic [pin_mux_pkg::NUM_CH-1:0][7:0]          i_video_data,
  input  wire  logic [pin_mux_pkg::NUM_CH-1:0]               i_video_loss_out_en,
  // Multi-purpose pins
  input  wire  logic [pin_mux_pkg::NUM_CH-1:0]               i_pin_in,
  output logic [pin_mux_pkg::NUM_CH-1:0]                     o_pin_out,
  output logic [pin_mux_pkg::NUM_CH-1:0]                     o_pin_oe,
  // Video output buses
  output logic [pin_mux_pkg::NUM_CH-1:0][7:0]                o_video_bus
);
  import pin_mux_pkg::*;

  logic [1:0][7:0]            pin_ctrl_reg;
  logic [1:0][7:0]            pin_ctrl_next;
  logic [7:0]                 bus_mode_reg;
  logic [7:0]                 bus_mode_next;
  logic [7:0]                 invert_reg;
  logic [7:0]                 invert_next;
  logic [7:0]                 second_sel_reg;
  logic [7:0]                 second_sel_next;
  logic [7:0]                 first_sel_reg;
  logic [7:0]                 first_sel_next;
  logic [7:0]                 rdata_reg;
  logic [7:0]                 rdata_next;
  logic [1:0]                 slot_reg;
  logic [1:0]                 slot_next;
  logic [NUM_CH-1:0]          pin_reg;
  logic [NUM_CH-1:0]          pin_next;
  logic [NUM_CH-1:0]          oe_reg;
  logic [NUM_CH-1:0][7:0]     bus_reg;
  logic [NUM_CH-1:0][7:0]     bus_next;
  pin_function_t              pin_code [NUM_CH];
  logic [NUM_CH-1:0]          pin_gp;
  logic [NUM_CH-1:0]          pin_inv;
  bus_mux_mode_t              bus_mode [NUM_CH];
  logic [1:0]                 first_src [NUM_CH];
  logic [1:0]                 second_src [NUM_CH];

  // Register writes
  always_comb
  begin
    pin_ctrl_next   = pin_ctrl_reg;
    bus_mode_next   = bus_mode_reg;
    invert_next     = invert_reg;
    second_sel_next = second_sel_reg;
    first_sel_next  = first_sel_reg;
    if (i_reg_wr)
    begin
      if (i_reg_addr == ADDR_PIN12_CTRL)
        pin_ctrl_next[0] = i_reg_wdata;
      else if (i_reg_addr == ADDR_PIN34_CTRL)
        pin_ctrl_next[1] = i_reg_wdata;
      else if (i_reg_addr == ADDR_BUS_MODE)
        bus_mode_next = i_reg_wdata;
      else if (i_reg_addr == ADDR_PIN_INVERT)
        invert_next = i_reg_wdata;
      else if (i_reg_addr == ADDR_SECOND_SEL)
        second_sel_next = i_reg_wdata;
      else if (i_reg_addr == ADDR_FIRST_SEL)
        first_sel_next = i_reg_wdata;
    end
  end

  // Register reads; the level bits show the pin, not the stored value
  always_comb
  begin
    rdata_next = RST_BYTE;
    if (i_reg_rd)
    begin
      if (i_reg_addr == ADDR_PIN12_CTRL)
      begin
        rdata_next = pin_ctrl_reg[0];
        rdata_next[GP_OFS] = i_pin_in[0];
        rdata_next[PIN_STRIDE + GP_OFS] = i_pin_in[1];
      end
      else if (i_reg_addr == ADDR_PIN34_CTRL)
      begin
        rdata_next = pin_ctrl_reg[1];
        rdata_next[GP_OFS] = i_pin_in[2];
        rdata_next[PIN_STRIDE + GP_OFS] = i_pin_in[3];
      end
      else if (i_reg_addr == ADDR_BUS_MODE)
        rdata_next = bus_mode_reg;
      else if (i_reg_addr == ADDR_PIN_INVERT)
        rdata_next = invert_reg;
      else if (i_reg_addr == ADDR_SECOND_SEL)
        rdata_next = second_sel_reg;
      else if (i_reg_addr == ADDR_FIRST_SEL)
        rdata_next = first_sel_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_ctrl_reg   <= {RST_PIN_CTRL, RST_PIN_CTRL};
      bus_mode_reg   <= RST_BUS_MODE;
      invert_reg     <= RST_PIN_INVERT;
      second_sel_reg <= RST_SECOND_SEL;
      first_sel_reg  <= RST_FIRST_SEL;
      rdata_reg      <= RST_BYTE;
    end
    else
    begin
      pin_ctrl_reg   <= pin_ctrl_next;
      bus_mode_reg   <= bus_mode_next;
      invert_reg     <= invert_next;
      second_sel_reg <= second_sel_next;
      first_sel_reg  <= first_sel_next;
      rdata_reg      <= rdata_next;
    end
  end

  // Interleave slot, shared by all buses so streams stay aligned
  always_comb
  begin
    slot_next = slot_reg + SLOT_STEP;
  end

  genvar p;
  generate
    for (p = 0; p < NUM_CH; p++)
    begin : g_chan
      always_comb
      begin
        pin_code[p]   = pin_function_t'(pin_ctrl_reg[p / 2][(p % 2) * PIN_STRIDE +: FN_W]);
        pin_gp[p]     = pin_ctrl_reg[p / 2][(p % 2) * PIN_STRIDE + GP_OFS];
        pin_inv[p]    = invert_reg[INVERT_POS + p];
        bus_mode[p]   = bus_mux_mode_t'(bus_mode_reg[p * SEL_W +: SEL_W]);
        first_src[p]  = first_sel_reg[p * SEL_W +: SEL_W];
        second_src[p] = second_sel_reg[p * SEL_W +: SEL_W];
      end

      // Pin function select
      always_comb
      begin
        logic lvl;
        lvl = pin_gp[p];
        case (pin_code[p])
          FN_HSYNC:     lvl = i_chan_timing[p].hsync_n;
          FN_VSYNC:     lvl = i_chan_timing[p].vsync_n;
          FN_FIELD:     lvl = i_chan_timing[p].field_even;
          FN_HACTIVE:   lvl = i_chan_timing[p].h_active;
          FN_VH_ACTIVE: lvl = i_chan_timing[p].v_active & i_chan_timing[p].h_active;
          FN_NO_VIDEO:  lvl = i_chan_timing[p].no_video;
          FN_CSYNC:     lvl = i_chan_timing[p].vsync_n & i_chan_timing[p].hsync_n;
          default:      lvl = pin_gp[p];
        endcase
        if (i_video_loss_out_en[p])
          lvl = i_chan_timing[p].video_loss;
        // Inversion also applies to the video-loss override
        pin_next[p] = lvl ^ pin_inv[p];
      end

      // Bus source select; one byte per clock from the chosen channel
      always_comb
      begin
        logic [1:0] src;
        src = first_src[p];
        case (bus_mode[p])
          MUX_TWO:  src = slot_reg[0] ? second_src[p] : first_src[p];
          MUX_FOUR: src = slot_reg;
          default:  src = first_src[p];
        endcase
        bus_next[p] = i_video_data[src];
      end

      a_hsync_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_video_loss_out_en[p] && pin_code[p] == FN_HSYNC && !pin_inv[p])
        |=> o_pin_out[p] == $past(i_chan_timing[p].hsync_n))
        else $error("pin does not follow horizontal sync");

      a_vsync_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_video_loss_out_en[p] && pin_code[p] == FN_VSYNC && !pin_inv[p])
        |=> o_pin_out[p] == $past(i_chan_timing[p].vsync_n))
        else $error("pin does not follow vertical sync");

      a_field_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_video_loss_out_en[p] && pin_code[p] == FN_FIELD && !pin_inv[p])
        |=> o_pin_out[p] == $past(i_chan_timing[p].field_even))
        else $error("field flag wrong on pin");

      a_hactive_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_video_loss_out_en[p] && pin_code[p] == FN_HACTIVE && !pin_inv[p])
        |=> o_pin_out[p] == $past(i_chan_timing[p].h_active))
        else $error("horizontal window wrong on pin");

      a_window_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_video_loss_out_en[p] && pin_code[p] == FN_VH_ACTIVE && !pin_inv[p])
        |=> o_pin_out[p] == ($past(i_chan_timing[p].v_active) && $past(i_chan_timing[p].h_active)))
        else $error("combined window wrong on pin");

      a_no_video_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_video_loss_out_en[p] && pin_code[p] == FN_NO_VIDEO && !pin_inv[p])
        |=> o_pin_out[p] == $past(i_chan_timing[p].no_video))
        else $error("no-video flag wrong on pin");

      a_csync_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_video_loss_out_en[p] && pin_code[p] == FN_CSYNC && !pin_inv[p])
        |=> o_pin_out[p] == ($past(i_chan_timing[p].hsync_n) && $past(i_chan_timing[p].vsync_n)))
        else $error("composite sync wrong on pin");

      a_gp_level_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_video_loss_out_en[p] && pin_code[p] == FN_GP_LEVEL)
        |=> o_pin_out[p] == ($past(pin_gp[p]) ^ $past(pin_inv[p])))
        else $error("general purpose level not driven");

      a_invert_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_video_loss_out_en[p] && pin_code[p] == FN_NO_VIDEO && pin_inv[p])
        |=> o_pin_out[p] != $past(i_chan_timing[p].no_video))
        else $error("inverted pin not inverted");

      a_loss_override: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_video_loss_out_en[p]
        |=> o_pin_out[p] == ($past(i_chan_timing[p].video_loss) ^ $past(pin_inv[p])))
        else $error("video loss not on pin");

      a_single_bus: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (bus_mode[p] == MUX_SINGLE)
        |=> o_video_bus[p] == $past(i_video_data[first_src[p]]))
        else $error("single mode bus has wrong source");

      a_two_ch_bus: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (bus_mode[p] == MUX_TWO && slot_reg[0])
        |=> o_video_bus[p] == $past(i_video_data[second_src[p]]))
        else $error("second stream has wrong source");

      a_first_stream: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (bus_mode[p] == MUX_TWO && !slot_reg[0])
        |=> o_video_bus[p] == $past(i_video_data[first_src[p]]))
        else $error("first stream has wrong source");

      a_four_ch_bus: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (bus_mode[p] == MUX_FOUR)
        |=> o_video_bus[p] == $past(i_video_data[slot_reg]))
        else $error("four channel interleave has wrong source");
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      slot_reg <= '0;
      pin_reg  <= '0;
      oe_reg   <= '0;
      bus_reg  <= '0;
    end
    else
    begin
      slot_reg <= slot_next;
      pin_reg  <= pin_next;
      oe_reg   <= '1;
      bus_reg  <= bus_next;
    end
  end

  a_pin_readback: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_reg_rd && i_reg_addr == ADDR_PIN12_CTRL)
    |=> o_reg_rdata[GP_OFS] == $past(i_pin_in[0]) && o_reg_rdata[PIN_STRIDE + GP_OFS] == $past(i_pin_in[1]))
    else $error("level bit readback is not the pin input");

  a_reset_sources: assert property (@(posedge i_clk)
    $rose(i_arst_n) |-> first_sel_reg == RST_FIRST_SEL && second_sel_reg == RST_SECOND_SEL)
    else $error("source selectors wrong after reset");

  assign o_reg_rdata = rdata_reg;
  assign o_pin_out   = pin_reg;
  assign o_pin_oe    = oe_reg;
  assign o_video_bus = bus_reg;
endmodule : sync_pin_and_video_bus_mux
`default_nettype wire

// file: test/video_sink.sv
// Downstream back-end model that keeps the previous byte of every video bus
`default_nettype none
module video_sink
(
  // Clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_arst_n,
  // Streams from the decoder
  input  wire logic [pin_mux_pkg::NUM_CH-1:0][7:0] i_video_bus,
  output logic      [pin_mux_pkg::NUM_CH-1:0][7:0] o_last_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  import pin_mux_pkg::*;

  // The byte history lets the bench judge interleave order without knowing the slot phase
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_last_bus <= '0;
    else
      o_last_bus <= i_video_bus;
  end
endmodule : video_sink
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the sync pin and video bus multiplexer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pin_mux_pkg::*;

  logic                    clk     = 1'b0;
  logic                    arst_n  = 1'b0;
  logic [7:0]              addr    = 8'h00;
  logic                    wr      = 1'b0;
  logic                    rd      = 1'b0;
  logic [7:0]              wdata   = 8'h00;
  chan_timing_t [NUM_CH-1:0] timing = '0;
  logic [NUM_CH-1:0][7:0]  vdata   = '0;
  logic [NUM_CH-1:0]       loss_en = '0;
  logic [NUM_CH-1:0]       pin_in  = '0;
  logic [3:0]              cnt     = 4'h0;
  logic [7:0]              rdata;
  logic [NUM_CH-1:0]       pin_out;
  logic [NUM_CH-1:0]       pin_oe;
  logic [NUM_CH-1:0][7:0]  vbus;
  logic [NUM_CH-1:0][7:0]  last_bus;
  int                      errors     = 0;
  int                      n_compared = 0;

  always #10 clk = ~clk;

  // Each channel byte carries its channel number plus one high and a running count low
  always @(posedge clk)
  begin
    cnt <= cnt + 4'h1;
    for (int c = 0; c < NUM_CH; c++)
      vdata[c] <= {4'(c + 1), cnt + 4'h1};
  end

  sync_pin_and_video_bus_mux i_sync_pin_and_video_bus_mux (
    .i_clk(clk), .i_arst_n(arst_n), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_chan_timing(timing), .i_video_data(vdata),
    .i_video_loss_out_en(loss_en), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_video_bus(vbus));

  video_sink i_video_sink (.i_clk(clk), .i_arst_n(arst_n), .i_video_bus(vbus), .o_last_bus(last_bus));

  task automatic close_out();
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  function automatic logic exp_pin(input int f, input chan_timing_t t, input logic gp);
    case (f)
      0: return t.hsync_n;
      1: return t.vsync_n;
      2: return t.field_even;
      3: return t.h_active;
      4: return t.v_active & t.h_active;
      5: return t.no_video;
      6: return t.hsync_n & t.vsync_n;
      default: return gp;
    endcase
  endfunction : exp_pin

  task automatic t_reset();
    chk({4'h0, pin_oe}, 8'h0F);
    rd_chk(ADDR_PIN12_CTRL, 8'h00);
    rd_chk(ADDR_PIN34_CTRL, 8'h00);
    rd_chk(ADDR_BUS_MODE, 8'h00);
    rd_chk(ADDR_PIN_INVERT, 8'h00);
    rd_chk(ADDR_SECOND_SEL, 8'h39);
    rd_chk(ADDR_FIRST_SEL, 8'hE4);
    wr_reg(ADDR_PIN_INVERT, 8'h5A);
    rd_chk(ADDR_PIN_INVERT, 8'h5A);
    wr_reg(8'hC7, 8'hFF);
    rd_chk(8'hC7, 8'h00);
  endtask : t_reset

  // Stored level bits are set opposite to pins 0, 2 and 3 so a stale readback shows
  task automatic t_gp_read();
    @(posedge clk);
    pin_in <= 4'b1010;
    wr_reg(ADDR_PIN12_CTRL, 8'h88);
    wr_reg(ADDR_PIN34_CTRL, 8'h0B);
    rd_chk(ADDR_PIN12_CTRL, 8'h80);
    rd_chk(ADDR_PIN34_CTRL, 8'h83);
  endtask : t_gp_read

  task automatic t_pins();
    logic [2:0]        fn;
    logic [3:0]        gp;
    logic [3:0]        en;
    logic [3:0]        e;
    chan_timing_t      tv [NUM_CH];
    for (int f = 0; f < 8; f++)
      for (int inv = 0; inv < 2; inv++)
        for (int j = 0; j < 6; j++)
        begin
          fn = 3'(f);
          gp = {j[1], j[2], j[0], ~j[0]};
          en = 4'(j * 5);
          wr_reg(ADDR_PIN12_CTRL, {gp[1], fn, gp[0], fn});
          wr_reg(ADDR_PIN34_CTRL, {gp[3], fn, gp[2], fn});
          wr_reg(ADDR_PIN_INVERT, {{4{inv[0]}}, 4'h0});
          @(posedge clk);
          loss_en <= en;
          for (int c = 0; c < NUM_CH; c++)
          begin
            tv[c] = chan_timing_t'(7'(j * 37 + c * 23 + f));
            timing[c] <= tv[c];
            e[c] = (en[c] ? tv[c].video_loss : exp_pin(f, tv[c], gp[c])) ^ inv[0];
          end
          @(posedge clk);
          #1;
          chk({4'h0, pin_out}, {4'h0, e});
        end
  endtask : t_pins

  // First and second sources differ on every bus so a wrong pick cannot hide
  task automatic t_bus();
    logic [3:0] hi;
    logic [3:0] prv;
    logic [3:0] fs;
    logic [3:0] ss;
    wr_reg(ADDR_FIRST_SEL, 8'h1B);
    wr_reg(ADDR_SECOND_SEL, 8'h4E);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(ADDR_BUS_MODE, {4{2'(m)}});
      repeat (2) @(posedge clk);
      repeat (8)
      begin
        @(posedge clk);
        #1;
        for (int b = 0; b < NUM_CH; b++)
        begin
          fs = 4'h4 - 4'(b);
          ss = 4'((b + 2) % 4 + 1);
          hi = vbus[b][7:4];
          prv = last_bus[b][7:4];
          chk({4'h0, vbus[b][3:0]}, {4'h0, cnt - 4'h1});
          case (m)
            1: chk({4'h0, hi}, {4'h0, (prv == fs) ? ss : fs});
            2: chk({4'h0, hi}, {4'h0, 4'(prv[1:0]) + 4'h1});
            default: chk({4'h0, hi}, {4'h0, fs});
          endcase
        end
      end
    end
  endtask : t_bus

  initial
  begin
    #100us;
    errors++;
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_gp_read();
    t_pins();
    t_bus();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
